/* include/mwd_pkg.sv */
// ********************************************************
// Shared constants for the motion wake detector
// ********************************************************
package mwd_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] MWD_IDX_AXIS_CTRL = 8'h10;
  localparam logic [7:0] MWD_IDX_THR_CTRL = 8'h13;
  localparam logic [7:0] MWD_IDX_SHADOW_CFG = 8'h14;
  localparam logic [7:0] MWD_IDX_STATUS = 8'h18;
  localparam logic [7:0] MWD_IDX_MASK = 8'h19;
  // Values after reset
  localparam logic [7:0] MWD_RST_BYTE = 8'h00;
  localparam logic [31:0] MWD_RST_WORD = 32'h0000_0000;
  // Field positions
  localparam int MWD_THR_MODE_BIT = 7;
  localparam int MWD_THR_ANDOR_BIT = 6;
  localparam int MWD_CFG_MUX_LSB = 4;
  localparam int MWD_CFG_CNTEN_BIT = 3;
  localparam int MWD_PD_LSB = 4;
  localparam int MWD_STAT_WAKE_BIT = 0;
  localparam int MWD_STAT_AXIS_LSB = 1;
  // Widths
  localparam int MWD_SAMPLE_W = 14;
  localparam int MWD_DELTA_W = 11;
  localparam int MWD_FIELD_W = 6;
  localparam int MWD_STAT_W = 4;
  localparam int MWD_AXES = 3;
  // Highest legal slice offset for an 11-bit delta
  localparam logic [2:0] MWD_SLICE_MAX = 3'h5;
  // AHB codes
  localparam logic [2:0] MWD_HSIZE_WORD = 3'h2;
  // Watch-mode sequencing
  typedef enum logic [2:0] {
    MWD_ST_IDLE = 3'b001,
    MWD_ST_PRIME = 3'b010,
    MWD_ST_RUN = 3'b100
  } mwd_state_t;
endpackage

/* include/mwd_axis_if.sv */
`timescale 1ns/1ps
// ********************************************************
// Link between the controller and one axis detector
// ********************************************************
interface mwd_axis_if;
  import mwd_pkg::*;
  logic step; // One sample to process
  logic prime; // First sample of watch mode
  logic use_base; // Delta against baseline
  logic count_en; // Detection counting on
  logic [2:0] slice_sel; // Delta slice offset
  logic [MWD_FIELD_W-1:0] threshold; // Axis threshold
  logic [MWD_FIELD_W-1:0] det_count; // Events minus one
  logic [MWD_SAMPLE_W-1:0] sample; // Current sample
  logic flag; // Axis wakeup flag
  modport ctrl (output step, prime, use_base, count_en, slice_sel,
    threshold, det_count, sample, input flag);
  modport axis (input step, prime, use_base, count_en, slice_sel,
    threshold, det_count, sample, output flag);
endinterface

/* rtl/mwd_axis.sv */
`timescale 1ns/1ps
// ********************************************************
// One axis: delta, slice, threshold and detection count
// ********************************************************
module mwd_axis
  import mwd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  mwd_axis_if.axis ax
);
  logic [MWD_SAMPLE_W-1:0] prev_reg, prev_next; // Last sample
  logic [MWD_SAMPLE_W-1:0] base_reg, base_next; // Baseline sample
  logic [MWD_FIELD_W-1:0] cnt_reg, cnt_next; // Consecutive hits
  logic flag_reg, flag_next; // Axis flag
  logic [MWD_SAMPLE_W-1:0] ref_smp; // Reference sample
  logic [MWD_SAMPLE_W:0] diff; // One bit wider, never wraps
  logic [MWD_SAMPLE_W:0] mag; // Absolute difference
  logic [MWD_DELTA_W-1:0] delta; // Clamped 11-bit delta
  logic [MWD_FIELD_W-1:0] slice; // Compared slice
  logic hit; // Delta above threshold

  // Six bits from offset s, saturated if any higher bit is set
  function automatic logic [MWD_FIELD_W-1:0] pick_slice(
    input logic [MWD_DELTA_W-1:0] d, input logic [2:0] s);
    logic [MWD_DELTA_W-1:0] sh;
    logic [2:0] sc;
    sc = (s > MWD_SLICE_MAX) ? MWD_SLICE_MAX : s;
    sh = d >> sc;
    pick_slice = (|sh[MWD_DELTA_W-1:MWD_FIELD_W]) ? '1
      : sh[MWD_FIELD_W-1:0];
  endfunction

  // Delta and next state
  always_comb
  begin
    ref_smp = ax.use_base ? base_reg : prev_reg;
    diff = {ax.sample[MWD_SAMPLE_W-1], ax.sample}
      - {ref_smp[MWD_SAMPLE_W-1], ref_smp};
    mag = diff[MWD_SAMPLE_W] ? (~diff + 1'b1) : diff;
    // Clamp so huge deltas still count as motion
    delta = (|mag[MWD_SAMPLE_W:MWD_DELTA_W]) ? '1
      : mag[MWD_DELTA_W-1:0];
    slice = pick_slice(delta, ax.slice_sel);
    hit = slice > ax.threshold;
    prev_next = prev_reg;
    base_next = base_reg;
    cnt_next = cnt_reg;
    flag_next = flag_reg;
    if (ax.step)
    begin
      prev_next = ax.sample;
      if (ax.prime)
      begin
        // Baseline is the first sample of watch mode
        base_next = ax.sample;
        cnt_next = '0;
        flag_next = 1'b0;
      end
      else
      begin
        // Count register holds events minus one
        flag_next = hit && (!ax.count_en
          || cnt_reg >= ax.det_count);
        // A miss breaks the run of detections
        cnt_next = !hit ? '0 : (&cnt_reg) ? cnt_reg
          : cnt_reg + 1'b1;
      end
    end
  end

  // State registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_reg <= '0;
      base_reg <= '0;
      cnt_reg <= '0;
      flag_reg <= 1'b0;
    end
    else
    begin
      prev_reg <= prev_next;
      base_reg <= base_next;
      cnt_reg <= cnt_next;
      flag_reg <= flag_next;
    end
  end

  assign ax.flag = flag_reg;

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_miss_clears;
    ax.step && !ax.prime && !hit |=> !ax.flag;
  endproperty
  a_miss_clears: assert property (p_miss_clears)
    else $error("flag set without threshold hit");

  property p_single_hit;
    ax.step && !ax.prime && hit && !ax.count_en |=> ax.flag;
  endproperty
  a_single_hit: assert property (p_single_hit)
    else $error("hit without counting did not flag");

  property p_count_wait;
    ax.step && !ax.prime && ax.count_en && cnt_reg < ax.det_count
      |=> !ax.flag;
  endproperty
  a_count_wait: assert property (p_count_wait)
    else $error("flag before detection count reached");

  property p_base_hold;
    !ax.prime |=> base_reg == $past(base_reg);
  endproperty
  a_base_hold: assert property (p_base_hold)
    else $error("baseline changed outside priming");

  property p_prev_track;
    ax.step |=> prev_reg == $past(ax.sample);
  endproperty
  a_prev_track: assert property (p_prev_track)
    else $error("previous sample not captured");

  c_count_run: cover property (ax.count_en && cnt_reg == 6'h02
    && ax.flag);
endmodule // mwd_axis

/* rtl/mwd_irq.sv */
`timescale 1ns/1ps
// ********************************************************
// Sticky status, read clear and masked interrupt
// ********************************************************
module mwd_irq
  import mwd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [MWD_STAT_W-1:0] event_set,
  input wire logic read_clear,
  input wire logic [MWD_STAT_W-1:0] mask,
  output logic [MWD_STAT_W-1:0] status,
  output logic irq
);
  logic [MWD_STAT_W-1:0] status_reg, status_next; // Sticky bits
  logic irq_reg, irq_next; // Registered level

  // New events win over a clearing read in the same cycle
  always_comb
  begin
    status_next = (read_clear ? '0 : status_reg) | event_set;
    irq_next = |(status_next & mask);
  end

  // Registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_reg <= '0;
      irq_reg <= 1'b0;
    end
    else
    begin
      status_reg <= status_next;
      irq_reg <= irq_next;
    end
  end

  assign status = status_reg;
  assign irq = irq_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_set_wins;
    read_clear && event_set[MWD_STAT_WAKE_BIT]
      |=> status[MWD_STAT_WAKE_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost under clearing read");

  property p_read_clears;
    read_clear && event_set == '0 |=> status == '0 && !irq;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("status not cleared by read");
endmodule // mwd_irq

/* rtl/mwd_top.sv */
`timescale 1ns/1ps
// Contract
// - Axis event when delta exceeds threshold
// - Independent 6-bit threshold per axis
// - Six shadows reached through selected data field
// - Selector codes pick threshold, count or none
// - Counting needs several detections before wakeup
// - Count loads events minus one, per axis
// - Axis flags combined by AND or OR
// - Combine bit zero: any active axis wakes
// - Combine bit one: all active axes wake
// - Powered-down axis left out of combine
// - Mode zero: delta against previous sample
// - Mode one: delta against first watch sample
// - Counters used only when count enable set
// - Selectable clamped 6-bit slice of delta
module mwd_top
  import mwd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic watch_mode,
  input wire logic sample_valid,
  input wire logic [MWD_SAMPLE_W-1:0] sample_x,
  input wire logic [MWD_SAMPLE_W-1:0] sample_y,
  input wire logic [MWD_SAMPLE_W-1:0] sample_z,
  output logic wakeup,
  output logic wake_irq
);
  // ********************************************************
  // Declarations
  // ********************************************************
  logic mode_reg, mode_next; // Baseline delta when set
  logic and_or_reg, and_or_next; // AND combine when set
  logic [2:0] sel_reg, sel_next; // Shadow selector
  logic cnten_reg, cnten_next; // Detection counting
  logic [2:0] mux_reg, mux_next; // Delta slice offset
  logic [2:0] pd_reg, pd_next; // Axis power-down bits
  logic [MWD_STAT_W-1:0] mask_reg, mask_next; // Interrupt mask
  logic [MWD_FIELD_W-1:0] thr_reg [MWD_AXES]; // Thresholds
  logic [MWD_FIELD_W-1:0] thr_next [MWD_AXES];
  logic [MWD_FIELD_W-1:0] cnt_reg [MWD_AXES]; // Detection counts
  logic [MWD_FIELD_W-1:0] cnt_next [MWD_AXES];
  logic wr_pend_reg, wr_pend_next; // Write in data phase
  logic [7:0] wr_idx_reg, wr_idx_next; // Index being written
  logic [31:0] hrdata_reg, hrdata_next; // Read data
  mwd_state_t state_reg, state_next; // Watch sequencing
  logic step_d_reg, step_d_next; // Flags just updated
  logic wake_reg, wake_next; // Combined wakeup level
  logic addr_ok; // Valid address phase
  logic [7:0] a_idx; // Index of address phase
  logic read_clear; // Status read in progress
  logic [3:0] dec_wr; // Decoded selector
  logic [3:0] dec_rd;
  logic step; // Sample to process
  logic [MWD_SAMPLE_W-1:0] samples [MWD_AXES];
  logic [MWD_AXES-1:0] flags; // Axis flags
  logic [MWD_AXES-1:0] active; // Axes not powered down
  logic any_hit; // OR combine
  logic all_hit; // AND combine
  logic combined; // Selected combine
  logic [MWD_STAT_W-1:0] events; // Sticky status sources
  logic [MWD_STAT_W-1:0] status; // Sticky status bits

  // Selector decode: {valid, is_count, axis[1:0]}
  function automatic logic [3:0] shadow_decode(input logic [2:0] s);
    logic [1:0] ix;
    ix = s[1:0] - 2'h1;
    shadow_decode = {s[1:0] != 2'h0, s[2], ix};
  endfunction

  // ********************************************************
  // AHB-Lite slave: zero wait states, always OKAY
  // ********************************************************
  assign addr_ok = hsel && htrans[1] && hready;
  assign a_idx = haddr[9:2];
  assign read_clear = addr_ok && !hwrite
    && haddr[31:10] == 22'h0 && a_idx == MWD_IDX_STATUS;
  assign dec_wr = shadow_decode(sel_reg);
  assign dec_rd = shadow_decode(sel_reg);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  // Register writes and read data
  always_comb
  begin
    mode_next = mode_reg;
    and_or_next = and_or_reg;
    sel_next = sel_reg;
    cnten_next = cnten_reg;
    mux_next = mux_reg;
    pd_next = pd_reg;
    mask_next = mask_reg;
    thr_next = thr_reg;
    cnt_next = cnt_reg;
    // Only whole-word writes inside the map are kept
    wr_pend_next = addr_ok && hwrite && hsize == MWD_HSIZE_WORD
      && haddr[31:10] == 22'h0;
    wr_idx_next = a_idx;
    hrdata_next = hrdata_reg;
    if (wr_pend_reg)
    begin
      case (wr_idx_reg)
        MWD_IDX_THR_CTRL:
        begin
          mode_next = hwdata[MWD_THR_MODE_BIT];
          and_or_next = hwdata[MWD_THR_ANDOR_BIT];
          // Data field lands in the selected shadow only
          if (dec_wr[3] && !dec_wr[2])
            thr_next[dec_wr[1:0]] = hwdata[MWD_FIELD_W-1:0];
          else if (dec_wr[3])
            cnt_next[dec_wr[1:0]] = hwdata[MWD_FIELD_W-1:0];
          // Otherwise the field is dropped
        end
        MWD_IDX_SHADOW_CFG:
        begin
          sel_next = hwdata[2:0];
          cnten_next = hwdata[MWD_CFG_CNTEN_BIT];
          mux_next = hwdata[MWD_CFG_MUX_LSB +: 3];
        end
        MWD_IDX_AXIS_CTRL: pd_next = hwdata[MWD_PD_LSB +: 3];
        MWD_IDX_MASK: mask_next = hwdata[MWD_STAT_W-1:0];
        default: ; // Unmapped writes vanish
      endcase
    end
    if (addr_ok && !hwrite)
    begin
      hrdata_next = MWD_RST_WORD;
      if (haddr[31:10] == 22'h0)
      begin
        case (a_idx)
          MWD_IDX_THR_CTRL:
          begin
            hrdata_next[MWD_THR_MODE_BIT] = mode_reg;
            hrdata_next[MWD_THR_ANDOR_BIT] = and_or_reg;
            // Nothing selected reads as zero
            if (dec_rd[3] && !dec_rd[2])
              hrdata_next[MWD_FIELD_W-1:0] = thr_reg[dec_rd[1:0]];
            else if (dec_rd[3])
              hrdata_next[MWD_FIELD_W-1:0] = cnt_reg[dec_rd[1:0]];
          end
          MWD_IDX_SHADOW_CFG:
          begin
            hrdata_next[2:0] = sel_reg;
            hrdata_next[MWD_CFG_CNTEN_BIT] = cnten_reg;
            hrdata_next[MWD_CFG_MUX_LSB +: 3] = mux_reg;
          end
          MWD_IDX_AXIS_CTRL: hrdata_next[MWD_PD_LSB +: 3] = pd_reg;
          MWD_IDX_STATUS: hrdata_next[MWD_STAT_W-1:0] = status;
          MWD_IDX_MASK: hrdata_next[MWD_STAT_W-1:0] = mask_reg;
          default: ; // Unmapped reads as zero
        endcase
      end
    end
  end

  // ********************************************************
  // Watch-mode sequencing and combine
  // ********************************************************
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      MWD_ST_IDLE: if (watch_mode) state_next = MWD_ST_PRIME;
      MWD_ST_PRIME:
      begin
        if (!watch_mode)
          state_next = MWD_ST_IDLE;
        else if (sample_valid)
          state_next = MWD_ST_RUN;
      end
      MWD_ST_RUN: if (!watch_mode) state_next = MWD_ST_IDLE;
      default: state_next = MWD_ST_IDLE;
    endcase
  end

  assign step = sample_valid && watch_mode
    && state_reg != MWD_ST_IDLE;
  assign samples[0] = sample_x;
  assign samples[1] = sample_y;
  assign samples[2] = sample_z;
  assign active = ~pd_reg;
  assign any_hit = |(flags & active);
  // An all-down set never wakes under AND
  assign all_hit = (&(flags | pd_reg)) && (|active);
  assign combined = and_or_reg ? all_hit : any_hit;
  assign events = {step_d_reg ? (flags & active) : 3'h0,
    step_d_reg && combined && state_reg == MWD_ST_RUN};

  // Wakeup level follows each processed sample
  always_comb
  begin
    step_d_next = step && state_reg == MWD_ST_RUN;
    wake_next = wake_reg;
    if (state_reg != MWD_ST_RUN)
      wake_next = 1'b0;
    else if (step_d_reg)
      wake_next = combined;
  end

  // ********************************************************
  // Registers
  // ********************************************************
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_reg <= 1'b0;
      and_or_reg <= 1'b0;
      sel_reg <= MWD_RST_BYTE[2:0];
      cnten_reg <= 1'b0;
      mux_reg <= MWD_RST_BYTE[2:0];
      pd_reg <= MWD_RST_BYTE[2:0];
      mask_reg <= MWD_RST_BYTE[MWD_STAT_W-1:0];
      thr_reg <= '{default: '0};
      cnt_reg <= '{default: '0};
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= MWD_RST_BYTE;
      hrdata_reg <= MWD_RST_WORD;
      state_reg <= MWD_ST_IDLE;
      step_d_reg <= 1'b0;
      wake_reg <= 1'b0;
    end
    else
    begin
      mode_reg <= mode_next;
      and_or_reg <= and_or_next;
      sel_reg <= sel_next;
      cnten_reg <= cnten_next;
      mux_reg <= mux_next;
      pd_reg <= pd_next;
      mask_reg <= mask_next;
      thr_reg <= thr_next;
      cnt_reg <= cnt_next;
      wr_pend_reg <= wr_pend_next;
      wr_idx_reg <= wr_idx_next;
      hrdata_reg <= hrdata_next;
      state_reg <= state_next;
      step_d_reg <= step_d_next;
      wake_reg <= wake_next;
    end
  end

  assign wakeup = wake_reg;

  // ********************************************************
  // Axis detectors and interrupt
  // ********************************************************
  mwd_axis_if ax_if [MWD_AXES] ();

  generate
    for (genvar g = 0; g < MWD_AXES; g++)
    begin : g_axis
      assign ax_if[g].step = step;
      assign ax_if[g].prime = state_reg == MWD_ST_PRIME;
      assign ax_if[g].use_base = mode_reg;
      assign ax_if[g].count_en = cnten_reg;
      assign ax_if[g].slice_sel = mux_reg;
      assign ax_if[g].threshold = thr_reg[g];
      assign ax_if[g].det_count = cnt_reg[g];
      assign ax_if[g].sample = samples[g];
      assign flags[g] = ax_if[g].flag;
      mwd_axis u_axis (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ax(ax_if[g])
      );
    end
  endgenerate

  mwd_irq u_irq (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .event_set(events),
    .read_clear(read_clear),
    .mask(mask_reg),
    .status(status),
    .irq(wake_irq)
  );

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_or_wake;
    state_reg == MWD_ST_RUN && step_d_reg && !and_or_reg
      && |(flags & ~pd_reg) |=> wakeup;
  endproperty
  a_or_wake: assert property (p_or_wake)
    else $error("OR combine missed an active axis");

  property p_and_wake;
    state_reg == MWD_ST_RUN && step_d_reg && and_or_reg
      && |(~flags & ~pd_reg) |=> !wakeup;
  endproperty
  a_and_wake: assert property (p_and_wake)
    else $error("AND combine woke with an idle axis");

  property p_pd_out;
    step_d_reg && !and_or_reg && (flags & ~pd_reg) == 3'h0
      |=> !wakeup;
  endproperty
  a_pd_out: assert property (p_pd_out)
    else $error("powered-down axis caused wakeup");

  property p_none_reads_zero;
    addr_ok && !hwrite && haddr[31:10] == 22'h0
      && a_idx == MWD_IDX_THR_CTRL && sel_reg[1:0] == 2'h0
      |=> hrdata[MWD_FIELD_W-1:0] == 6'h00;
  endproperty
  a_none_reads_zero: assert property (p_none_reads_zero)
    else $error("unselected shadow read not zero");

  property p_thr_write;
    wr_pend_reg && wr_idx_reg == MWD_IDX_THR_CTRL && sel_reg == 3'h1
      |=> thr_reg[0] == $past(hwdata[MWD_FIELD_W-1:0]);
  endproperty
  a_thr_write: assert property (p_thr_write)
    else $error("X threshold shadow not written");

  c_or_wake: cover property (!and_or_reg && wakeup);
  c_and_wake: cover property (and_or_reg && wakeup);
  c_base_wake: cover property (mode_reg && wake_irq);
endmodule // mwd_top

/* verification/mwd_top_test.sv */
`timescale 1ns/1ps
// ********************************************************
// Self-checking bench for the motion wake detector
// ********************************************************
module mwd_top_test
  import mwd_pkg::*;
;
  logic core_clk; // Sample clock, 40 MHz
  logic rst_n; // Async reset, active low
  logic hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic watch_mode, sample_valid, wakeup, wake_irq;
  logic [MWD_SAMPLE_W-1:0] sample_x, sample_y, sample_z;
  int num_errors; // Mismatches seen
  int num_checks; // Comparisons made
  logic [31:0] q; // Last read word

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  mwd_top mwd_top_i (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .watch_mode(watch_mode),
    .sample_valid(sample_valid), .sample_x(sample_x),
    .sample_y(sample_y), .sample_z(sample_z), .wakeup(wakeup),
    .wake_irq(wake_irq));

  // ********************************************************
  // Clock, verdict and comparison
  // ********************************************************
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic results();
    if (num_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ********************************************************
  // Bus and sample drivers
  // ********************************************************
  // Bounded wait for ready; a hang ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 40);
    if (hreadyout !== 1'b1)
    begin
      num_errors++;
      results();
    end
  endtask

  // One word transfer; read data taken at the data phase edge
  task automatic bus(input logic [7:0] idx, input logic we,
    input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {22'h000000, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= we;
    hsize <= MWD_HSIZE_WORD;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    wait_rdy();
    q = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  // One sample pulse, then wakeup judged once it has settled
  task automatic smp(input logic [13:0] x, input logic [13:0] y,
    input logic [13:0] z, input logic ew);
    sample_valid <= 1'b1;
    sample_x <= x;
    sample_y <= y;
    sample_z <= z;
    @(posedge core_clk);
    sample_valid <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk({31'h0, wakeup}, {31'h0, ew});
  endtask

  // Leave, re-enter watch mode and prime with a zero sample
  task automatic enter();
    watch_mode <= 1'b0;
    @(posedge core_clk);
    watch_mode <= 1'b1;
    repeat (2) @(posedge core_clk);
    smp(14'h0000, 14'h0000, 14'h0000, 1'b0);
  endtask

  // ********************************************************
  // Scenarios
  // ********************************************************
  task automatic t_regs();
    logic [7:0] idx [6];
    idx = '{MWD_IDX_AXIS_CTRL, MWD_IDX_THR_CTRL, MWD_IDX_SHADOW_CFG,
      MWD_IDX_STATUS, MWD_IDX_MASK, 8'h11};
    foreach (idx[i])
    begin
      bus(idx[i], 1'b0, 8'h00);
      chk(q, MWD_RST_WORD);
    end
  endtask

  // Every selector code written then read back; none codes stay 0
  task automatic t_shadow();
    logic [5:0] v;
    for (int i = 0; i < 8; i++)
    begin
      bus(MWD_IDX_SHADOW_CFG, 1'b1, 8'(i));
      bus(MWD_IDX_THR_CTRL, 1'b1, {2'b00, 6'(i * 5 + 3)});
    end
    for (int i = 0; i < 8; i++)
    begin
      v = (i % 4 == 0) ? 6'h00 : 6'(i * 5 + 3);
      bus(MWD_IDX_SHADOW_CFG, 1'b1, 8'(i));
      bus(MWD_IDX_THR_CTRL, 1'b0, 8'h00);
      chk(q, {26'h0, v});
    end
  endtask

  // Strictly greater, moving window, sticky status and interrupt
  task automatic t_or();
    bus(MWD_IDX_MASK, 1'b1, 8'h01);
    bus(MWD_IDX_SHADOW_CFG, 1'b1, 8'h01);
    bus(MWD_IDX_THR_CTRL, 1'b1, 8'h0A);
    enter();
    smp(14'h000A, 14'h0000, 14'h0000, 1'b0);
    smp(14'h0015, 14'h0000, 14'h0000, 1'b1);
    chk({31'h0, wake_irq}, 32'h1);
    bus(MWD_IDX_STATUS, 1'b0, 8'h00);
    chk(q, 32'h3);
    smp(14'h0015, 14'h0000, 14'h0000, 1'b0);
    bus(MWD_IDX_STATUS, 1'b0, 8'h00);
    chk(q, 32'h0);
    chk({31'h0, wake_irq}, 32'h0);
  endtask

  // AND of active axes; powered-down axes drop out
  task automatic t_and();
    bus(MWD_IDX_SHADOW_CFG, 1'b1, 8'h02);
    bus(MWD_IDX_THR_CTRL, 1'b1, 8'h4A);
    enter();
    smp(14'h001E, 14'h001E, 14'h0000, 1'b0);
    bus(MWD_IDX_AXIS_CTRL, 1'b1, 8'h40);
    enter();
    smp(14'h001E, 14'h001E, 14'h0000, 1'b1);
    bus(MWD_IDX_AXIS_CTRL, 1'b1, 8'h10);
    bus(MWD_IDX_THR_CTRL, 1'b1, 8'h0A);
    enter();
    smp(14'h001E, 14'h0000, 14'h0000, 1'b0);
    bus(MWD_IDX_AXIS_CTRL, 1'b1, 8'h00);
  endtask

  // Two consecutive hits needed; a miss restarts the run
  task automatic t_count();
    bus(MWD_IDX_SHADOW_CFG, 1'b1, 8'h05);
    bus(MWD_IDX_THR_CTRL, 1'b1, 8'h01);
    bus(MWD_IDX_SHADOW_CFG, 1'b1, 8'h09);
    enter();
    smp(14'h0014, 14'h0000, 14'h0000, 1'b0);
    smp(14'h0014, 14'h0000, 14'h0000, 1'b0);
    smp(14'h0028, 14'h0000, 14'h0000, 1'b0);
    smp(14'h003C, 14'h0000, 14'h0000, 1'b1);
    bus(MWD_IDX_SHADOW_CFG, 1'b1, 8'h01);
    enter();
    smp(14'h0014, 14'h0000, 14'h0000, 1'b1);
  endtask

  // Baseline deltas, slice offset one, clamp at slice zero
  task automatic t_base();
    bus(MWD_IDX_SHADOW_CFG, 1'b1, 8'h11);
    bus(MWD_IDX_THR_CTRL, 1'b1, 8'h8A);
    enter();
    smp(14'h0015, 14'h0000, 14'h0000, 1'b0);
    smp(14'h0016, 14'h0000, 14'h0000, 1'b1);
    bus(MWD_IDX_SHADOW_CFG, 1'b1, 8'h01);
    bus(MWD_IDX_THR_CTRL, 1'b1, 8'hBE);
    enter();
    smp(14'h0064, 14'h0000, 14'h0000, 1'b1);
  endtask

  // ********************************************************
  // Main sequence
  // ********************************************************
  initial
  begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = MWD_HSIZE_WORD;
    hwdata = 32'h0000_0000;
    watch_mode = 1'b0;
    sample_valid = 1'b0;
    sample_x = 14'h0000;
    sample_y = 14'h0000;
    sample_z = 14'h0000;
    num_errors = 0;
    num_checks = 0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_shadow();
    t_or();
    t_and();
    t_count();
    t_base();
    results();
  end
endmodule // mwd_top_test
